/* File: dsa_params.svh */
`ifndef DSA_PARAMS_SVH
`define DSA_PARAMS_SVH

// ----------------------------------------------------------------------
// Character framing and calibration
// ----------------------------------------------------------------------
`define DSA_DATA_BITS     8
`define DSA_CAL_LOW_BITS  8
`define DSA_PERIOD_SHIFT  3
`define DSA_BREAK_BITS    9

// ----------------------------------------------------------------------
// Bit-rate limits as system clock divisors
// ----------------------------------------------------------------------
`define DSA_MIN_RATE_DIV  512
`define DSA_MAX_RATE_DIV  4

// ----------------------------------------------------------------------
// Buffering and reset values
// ----------------------------------------------------------------------
`define DSA_FIFO_DEPTH    8
`define DSA_LINE_IDLE     1'b1
`define DSA_PIN_RST_IDLE  1'b1

`endif

/* File: dsa_pkg.sv */
package dsa_pkg;

  // --------------------------------------------------------------------
  // State encodings
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CAL_WAIT_HIGH = 2'h0,
    CAL_IDLE      = 2'h1,
    CAL_MEAS      = 2'h3,
    CAL_READY     = 2'h2
  } dsa_cal_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } dsa_rx_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_START = 2'h1,
    TX_DATA  = 2'h3,
    TX_STOP  = 2'h2
  } dsa_tx_type;

  // --------------------------------------------------------------------
  // Received character carrier
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } dsa_byte_type;

endpackage

/* File: dsa_top.sv */
// Contract
// [RQ1] Frame: start, eight data LSB first, stop.
// [RQ2] Stay silent until first host character.
// [RQ3] Host sends 80H first after reset.
// [RQ4] Measure eight-bit low span, set bit rate.
// [RQ5] All timing logic runs on system clock.
// [RQ6] Counters cover bit period of clock/512.
// [RQ7] Host rate at most clock/8, limit clock/4.
// [RQ8] Nine-bit low break resets auto-baud.
// [RQ9] Host resends 80H after a break.
// [RQ10] Low external reset pin resets device.
// [RQ11] Low debug line in stop resets system.
// [RQ12] Bit period is one eighth of span.
`timescale 1ns/1ps
`include "dsa_params.svh"

// ----------------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------------
module dsa_fifo #(
  parameter int WIDTH = `DSA_DATA_BITS,
  parameter int DEPTH = `DSA_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import dsa_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next          = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end
endmodule

// ----------------------------------------------------------------------
// Debug serial port with auto-baud
// ----------------------------------------------------------------------
module dsa_top #(
  parameter int PERIOD_MAX = `DSA_MIN_RATE_DIV,
  parameter int FIFO_DEPTH = `DSA_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Device pins
  input  wire logic         ext_reset_n,
  input  wire logic         debug_line_in,
  output logic              debug_line_out,
  output logic              debug_line_oe,
  // System control
  input  wire logic         stop_mode,
  output logic              sys_reset_req,
  output logic              cal_locked,
  // Received characters
  output dsa_pkg::dsa_byte_type rx_byte,
  // Characters to send
  input  wire logic [7:0]   tx_data,
  input  wire logic         tx_valid,
  output logic              tx_ready
);
  import dsa_pkg::*;

  localparam int PW = $clog2(PERIOD_MAX + 1);
  localparam int CW = $clog2((`DSA_BREAK_BITS + 1) * PERIOD_MAX + 1);
  localparam logic [CW-1:0] MEAS_MAX =
    CW'(`DSA_CAL_LOW_BITS * PERIOD_MAX + `DSA_CAL_LOW_BITS - 1);
  localparam logic [PW-1:0] MIN_PERIOD = PW'(`DSA_MAX_RATE_DIV);
  localparam logic [2:0]    LAST_BIT   = 3'(`DSA_DATA_BITS - 1);

  if (PERIOD_MAX < `DSA_MAX_RATE_DIV) begin : g_bad_period
    $error("PERIOD_MAX is below the shortest bit period.");
  end

  function automatic logic [PW-1:0] fn_half(input logic [PW-1:0] p);
    return p >> 1;
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers and system reset request
  // --------------------------------------------------------------------
  logic line_meta_reg, line_s_reg, rst_meta_reg, rst_s_reg;
  logic sys_reset_reg, sys_reset_next;

  always_comb begin
    sys_reset_next = !rst_s_reg || (stop_mode && !line_s_reg); // [RQ10] [RQ11]
  end

  // Everything runs on the system clock; no second domain exists. [RQ5]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_meta_reg <= `DSA_LINE_IDLE;
      line_s_reg    <= `DSA_LINE_IDLE;
      rst_meta_reg  <= `DSA_PIN_RST_IDLE;
      rst_s_reg     <= `DSA_PIN_RST_IDLE;
      sys_reset_reg <= 1'b0;
    end else begin
      line_meta_reg <= debug_line_in;
      line_s_reg    <= line_meta_reg;
      rst_meta_reg  <= ext_reset_n;
      rst_s_reg     <= rst_meta_reg;
      sys_reset_reg <= sys_reset_next;
    end
  end

  assign sys_reset_req = sys_reset_reg;

  // --------------------------------------------------------------------
  // Auto-baud detector and break watch
  // --------------------------------------------------------------------
  dsa_cal_type   cal_state_reg, cal_state_next;
  dsa_tx_type    tx_state_reg, tx_state_next;
  logic [CW-1:0] meas_cnt_reg, meas_cnt_next;
  logic [CW-1:0] brk_cnt_reg, brk_cnt_next;
  logic [PW-1:0] period_reg, period_next;
  logic [PW-1:0] meas_period;
  logic [CW-1:0] brk_lim;
  logic          brk_hit;

  assign meas_period = PW'(meas_cnt_reg >> `DSA_PERIOD_SHIFT); // [RQ12]
  // Nine bits plus half a bit, so a received all-zero character is no break.
  assign brk_lim = CW'(period_reg) * CW'(`DSA_BREAK_BITS)
                 + CW'(fn_half(period_reg));
  assign brk_hit = (brk_cnt_reg >= brk_lim);
  assign cal_locked = (cal_state_reg == CAL_READY);

  always_comb begin
    cal_state_next = cal_state_reg;
    meas_cnt_next  = meas_cnt_reg;
    brk_cnt_next   = brk_cnt_reg;
    period_next    = period_reg;
    if (!rst_s_reg) begin
      cal_state_next = CAL_WAIT_HIGH; // [RQ10]
      brk_cnt_next   = '0;
    end else begin
      unique case (cal_state_reg)
        CAL_WAIT_HIGH: begin
          if (line_s_reg) begin
            cal_state_next = CAL_IDLE; // [RQ9]
          end
        end
        CAL_IDLE: begin
          if (!line_s_reg) begin
            cal_state_next = CAL_MEAS; // [RQ3]
            meas_cnt_next  = CW'(1);
          end
        end
        CAL_MEAS: begin
          if (line_s_reg) begin
            if (meas_period >= MIN_PERIOD) begin
              cal_state_next = CAL_READY; // [RQ4] [RQ7]
              period_next    = meas_period; // [RQ12]
              brk_cnt_next   = '0;
            end else begin
              cal_state_next = CAL_WAIT_HIGH;
            end
          end else if (meas_cnt_reg == MEAS_MAX) begin
            cal_state_next = CAL_WAIT_HIGH; // [RQ6]
          end else begin
            meas_cnt_next = meas_cnt_reg + 1'b1; // [RQ4]
          end
        end
        CAL_READY: begin
          // Our own low drive must not count toward a break.
          if (line_s_reg || tx_state_reg != TX_IDLE) begin
            brk_cnt_next = '0;
          end else if (brk_hit) begin
            cal_state_next = CAL_WAIT_HIGH; // [RQ8]
            brk_cnt_next   = '0;
          end else begin
            brk_cnt_next = brk_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_state_reg <= CAL_WAIT_HIGH;
      meas_cnt_reg  <= '0;
      brk_cnt_reg   <= '0;
      period_reg    <= '0;
    end else begin
      cal_state_reg <= cal_state_next;
      meas_cnt_reg  <= meas_cnt_next;
      brk_cnt_reg   <= brk_cnt_next;
      period_reg    <= period_next;
    end
  end

  // --------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------
  dsa_rx_type    rx_state_reg, rx_state_next;
  logic [PW-1:0] rx_tmr_reg, rx_tmr_next;
  logic [2:0]    rx_bit_reg, rx_bit_next;
  logic [7:0]    rx_shift_reg, rx_shift_next;
  dsa_byte_type  rx_byte_reg, rx_byte_next;

  always_comb begin
    rx_state_next      = rx_state_reg;
    rx_tmr_next        = rx_tmr_reg - 1'b1;
    rx_bit_next        = rx_bit_reg;
    rx_shift_next      = rx_shift_reg;
    rx_byte_next       = rx_byte_reg;
    rx_byte_next.valid = 1'b0;
    if (cal_state_reg != CAL_READY) begin
      rx_state_next = RX_IDLE;
    end else begin
      unique case (rx_state_reg)
        RX_IDLE: begin
          if (!line_s_reg && tx_state_reg == TX_IDLE) begin
            rx_state_next = RX_START; // [RQ12]
            rx_tmr_next   = fn_half(period_reg) - 1'b1;
          end
        end
        RX_START: begin
          if (rx_tmr_reg == '0) begin
            rx_state_next = line_s_reg ? RX_IDLE : RX_DATA;
            rx_tmr_next   = period_reg - 1'b1;
            rx_bit_next   = '0;
          end
        end
        RX_DATA: begin
          if (rx_tmr_reg == '0) begin
            rx_shift_next = {line_s_reg, rx_shift_reg[7:1]}; // [RQ1]
            rx_tmr_next   = period_reg - 1'b1;
            rx_bit_next   = rx_bit_reg + 1'b1;
            if (rx_bit_reg == LAST_BIT) begin
              rx_state_next = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tmr_reg == '0) begin
            rx_state_next = RX_IDLE;
            // A character without its stop bit is dropped.
            if (line_s_reg) begin
              rx_byte_next.valid = 1'b1; // [RQ1]
              rx_byte_next.data  = rx_shift_reg;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_tmr_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
      rx_byte_reg  <= '0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_tmr_reg   <= rx_tmr_next;
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_byte_reg  <= rx_byte_next;
    end
  end

  assign rx_byte = rx_byte_reg;

  // --------------------------------------------------------------------
  // Transmitter fed by the FIFO
  // --------------------------------------------------------------------
  logic [PW-1:0] tx_tmr_reg, tx_tmr_next;
  logic [2:0]    tx_bit_reg, tx_bit_next;
  logic [7:0]    tx_shift_reg, tx_shift_next;
  logic          tx_oe_reg, tx_oe_next;
  logic [7:0]    fifo_data;
  logic          fifo_valid;
  logic          tx_launch;

  dsa_fifo #(
    .WIDTH     (`DSA_DATA_BITS),
    .DEPTH     (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (tx_launch)
  );

  // The line is shared, so sending waits for the receiver to be idle.
  // A byte popped while the reset pin is low would be lost, so wait.
  assign tx_launch = (tx_state_reg == TX_IDLE) && fifo_valid && line_s_reg
                  && (cal_state_reg == CAL_READY) && (rx_state_reg == RX_IDLE)
                  && rst_s_reg; // [RQ10]

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_tmr_next   = tx_tmr_reg - 1'b1;
    tx_bit_next   = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    tx_oe_next    = tx_oe_reg;
    if (!rst_s_reg) begin
      tx_state_next = TX_IDLE;
      tx_oe_next    = 1'b0;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          tx_oe_next = 1'b0; // [RQ2]
          if (tx_launch) begin
            tx_state_next = TX_START; // [RQ1]
            tx_shift_next = fifo_data;
            tx_tmr_next   = period_reg - 1'b1; // [RQ12]
            tx_oe_next    = 1'b1;
          end
        end
        TX_START: begin
          if (tx_tmr_reg == '0) begin
            tx_state_next = TX_DATA;
            tx_bit_next   = '0;
            tx_tmr_next   = period_reg - 1'b1;
            tx_oe_next    = !tx_shift_reg[0]; // [RQ1]
          end
        end
        TX_DATA: begin
          if (tx_tmr_reg == '0) begin
            tx_tmr_next = period_reg - 1'b1;
            tx_bit_next = tx_bit_reg + 1'b1;
            if (tx_bit_reg == LAST_BIT) begin
              tx_state_next = TX_STOP;
              tx_oe_next    = 1'b0; // [RQ1]
            end else begin
              tx_shift_next = tx_shift_reg >> 1;
              tx_oe_next    = !tx_shift_reg[1];
            end
          end
        end
        TX_STOP: begin
          if (tx_tmr_reg == '0) begin
            tx_state_next = TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_tmr_reg   <= '0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= '0;
      tx_oe_reg    <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_tmr_reg   <= tx_tmr_next;
      tx_bit_reg   <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      tx_oe_reg    <= tx_oe_next;
    end
  end

  // Open-drain: the pin is only ever pulled low.
  assign debug_line_out = 1'b0;
  assign debug_line_oe  = tx_oe_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_launch;
    tx_state_reg == TX_IDLE && tx_launch && rst_s_reg;
  endsequence

  sequence s_cal_done;
    cal_state_reg == CAL_MEAS && line_s_reg && rst_s_reg
      && meas_period >= MIN_PERIOD;
  endsequence

  a_no_tx_uncal: assert property ( // [RQ2]
    cal_state_reg != CAL_READY && tx_state_reg == TX_IDLE |=> !debug_line_oe)
    else $error("Line driven before calibration.");

  a_cal_period: assert property ( // [RQ4]
    s_cal_done |=> cal_state_reg == CAL_READY
      && period_reg == PW'($past(meas_cnt_reg) >> `DSA_PERIOD_SHIFT))
    else $error("Bit period not one eighth of low span.");

  a_meas_bound: assert property ( // [RQ6]
    cal_state_reg == CAL_MEAS |-> meas_cnt_reg <= MEAS_MAX)
    else $error("Measurement counter overran.");

  a_break_reset: assert property ( // [RQ8]
    cal_state_reg == CAL_READY && rst_s_reg && !line_s_reg
      && tx_state_reg == TX_IDLE && brk_hit
      |=> cal_state_reg == CAL_WAIT_HIGH && rx_state_reg == RX_IDLE)
    else $error("Break did not restart calibration.");

  a_ext_reset: assert property ( // [RQ10]
    $fell(rst_s_reg) |=> sys_reset_req && cal_state_reg == CAL_WAIT_HIGH)
    else $error("External reset not followed.");

  a_stop_wake: assert property ( // [RQ11]
    stop_mode && !line_s_reg |=> sys_reset_req)
    else $error("Low line in stop did not reset.");

  a_tx_start_bit: assert property ( // [RQ1]
    s_launch |=> debug_line_oe && tx_state_reg == TX_START
      && tx_tmr_reg == period_reg - 1'b1)
    else $error("Start bit not driven low.");

  a_tx_stop_bit: assert property ( // [RQ1]
    tx_state_reg == TX_STOP |-> !debug_line_oe)
    else $error("Stop bit not released high.");

  a_rx_deliver: assert property ( // [RQ1]
    rx_state_reg == RX_STOP && rx_tmr_reg == '0 && line_s_reg
      && cal_state_reg == CAL_READY
      |=> rx_byte.valid && rx_byte.data == $past(rx_shift_reg) ##1
      !rx_byte.valid)
    else $error("Received character not delivered once.");

  a_rx_mid_bit: assert property ( // [RQ12]
    rx_state_reg == RX_IDLE && cal_state_reg == CAL_READY && !line_s_reg
      && tx_state_reg == TX_IDLE
      |=> rx_state_reg == RX_START
      && rx_tmr_reg == fn_half(period_reg) - 1'b1)
    else $error("Start bit not sampled at mid-bit.");
endmodule

/* File: dsa_fifo_unused_guard.sv */
`timescale 1ns/1ps
// This file intentionally declares nothing beyond a timescale.

/* File: dsa_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Host tool on the far side of the debug line
// ----------------------------------------------------------------------
module dsa_host_model (
  // Clock
  input  wire logic clk_sys,
  // Resolved line and the host's own open-drain drive
  input  wire logic line,
  output logic      host_drive
);
  int         per;
  logic [7:0] got_q[$];

  initial begin
    host_drive = 1'b1;
    per        = 8;
  end

  // Start low, eight data bits from bit 0 up, stop high.
  task automatic send_char(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      host_drive <= fr[i];
      repeat (per - 1) @(posedge clk_sys);
    end
  endtask

  // The host never runs faster than one eighth of the system clock.
  task automatic calibrate(input int p);
    per = p;
    send_char(8'h80);
  endtask

  task automatic send_low(input int n);
    @(posedge clk_sys);
    host_drive <= 1'b0;
    repeat (n) @(posedge clk_sys);
    host_drive <= 1'b1;
  endtask

  // A low line that the host is not pulling is a device character.
  // A bad stop bit is stored as unknown so that every compare fails.
  always begin : rx_proc
    logic [7:0] b;
    @(posedge clk_sys);
    if (line === 1'b0 && host_drive === 1'b1) begin
      repeat (per / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (per) @(posedge clk_sys);
        b[i] = line;
      end
      repeat (per) @(posedge clk_sys);
      got_q.push_back((line === 1'b1) ? b : 8'hxx);
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------------
module tb;
  import dsa_pkg::*;

  logic         clk_sys;
  logic         rst;
  logic         ext_reset_n;
  logic         stop_mode;
  logic [7:0]   tx_data;
  logic         tx_valid;
  logic         tx_ready;
  logic         debug_line_out;
  logic         debug_line_oe;
  logic         sys_reset_req;
  logic         cal_locked;
  logic         host_drive;
  wire logic    line;
  dsa_byte_type rx_byte;
  int           fail_count = 0;
  int           n_tests    = 0;
  int           cyc        = 0;
  logic [7:0]   rx_q[$];
  logic [7:0]   rx_tab[4] = '{8'h55, 8'h00, 8'hA3, 8'hFF};

  // Open-drain wire with a pull-up: either party may pull it low.
  assign line = (debug_line_oe ? debug_line_out : 1'b1) & host_drive;

  dsa_top dut_u (
    .clk_sys(clk_sys), .rst(rst), .ext_reset_n(ext_reset_n),
    .debug_line_in(line), .debug_line_out(debug_line_out),
    .debug_line_oe(debug_line_oe), .stop_mode(stop_mode),
    .sys_reset_req(sys_reset_req), .cal_locked(cal_locked),
    .rx_byte(rx_byte), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  dsa_host_model host_u (
    .clk_sys(clk_sys), .line(line), .host_drive(host_drive)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (rx_byte.valid === 1'b1) begin
      rx_q.push_back(rx_byte.data);
    end
  end

  // The slowest rate dominates the run, so the ceiling leaves margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      $display("Error cycle_limit expected %0d seen %0d", 60000, cyc);
      conclude();
    end
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge clk_sys);
    tx_data  <= b;
    tx_valid <= 1'b1;
    @(posedge clk_sys);
    tx_valid <= 1'b0;
  endtask

  task automatic wait_got(input int n, input int lim);
    for (int i = 0; i < lim && host_u.got_q.size() < n; i++) begin
      @(posedge clk_sys);
    end
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_silent();
    int bad;
    bad = 0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      tx_data  <= 8'h30 + 8'(i);
      tx_valid <= 1'b1;
    end
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    #1 chk("tx_ready_full", 8'h00, {7'h00, tx_ready});
    repeat (200) begin
      @(posedge clk_sys);
      #1 if (debug_line_oe !== 1'b0) bad++;
    end
    chk("oe_before_cal", 8'h00, 8'(bad));
  endtask

  task automatic t_cal(input int p);
    host_u.calibrate(p);
    chk("cal_locked", 8'h01, {7'h00, cal_locked});
  endtask

  task automatic t_drain();
    wait_got(8, 3000);
    repeat (300) @(posedge clk_sys);
    chk("tx_count", 8'h08, 8'(host_u.got_q.size()));
    chk("tx_ready_free", 8'h01, {7'h00, tx_ready});
    for (int i = 0; i < 8 && i < host_u.got_q.size(); i++) begin
      chk("tx_byte", 8'h30 + 8'(i), host_u.got_q[i]);
    end
    host_u.got_q.delete();
  endtask

  // A zero byte is nine bit times low and must not count as a break.
  task automatic t_rx(input int p);
    rx_q.delete();
    foreach (rx_tab[i]) host_u.send_char(rx_tab[i]);
    repeat (p) @(posedge clk_sys);
    chk("rx_count", 8'h04, 8'(rx_q.size()));
    for (int i = 0; i < 4 && i < rx_q.size(); i++) begin
      chk("rx_byte", rx_tab[i], rx_q[i]);
    end
    chk("locked_after_zero", 8'h01, {7'h00, cal_locked});
  endtask

  task automatic t_tx(input logic [7:0] b, input int p);
    push(b);
    wait_got(1, 14 * p);
    chk("tx_count", 8'h01, 8'(host_u.got_q.size()));
    chk("tx_byte", b, host_u.got_q[0]);
    host_u.got_q.delete();
  endtask

  task automatic t_break(input int p);
    host_u.send_low(10 * p);
    repeat (4) @(posedge clk_sys);
    chk("locked_after_break", 8'h00, {7'h00, cal_locked});
  endtask

  task automatic t_extrst();
    @(posedge clk_sys);
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk("req_pin", 8'h01, {7'h00, sys_reset_req});
    chk("locked_pin", 8'h00, {7'h00, cal_locked});
    @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("req_pin_off", 8'h00, {7'h00, sys_reset_req});
  endtask

  // Low line only wakes the system while stopped; running, it is data.
  task automatic t_stopwake();
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      stop_mode <= 1'(s);
      fork
        host_u.send_low(8);
        begin
          repeat (6) @(posedge clk_sys);
          #1 chk("req_stop", 8'(s), {7'h00, sys_reset_req});
        end
      join
      repeat (5) @(posedge clk_sys);
      #1 chk("req_stop_off", 8'h00, {7'h00, sys_reset_req});
    end
    @(posedge clk_sys);
    stop_mode <= 1'b0;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rst         = 1'b1;
    ext_reset_n = 1'b1;
    stop_mode   = 1'b0;
    tx_data     = 8'h00;
    tx_valid    = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_silent();
    t_cal(8);
    t_drain();
    t_rx(8);
    t_break(8);
    t_cal(16);
    t_rx(16);
    t_tx(8'h5A, 16);
    t_extrst();
    t_stopwake();
    t_cal(512);
    t_tx(8'hC6, 512);
    t_rx(512);
    conclude();
  end
endmodule
